// ==== verilog/spi_flash_write_protect_ctrl.v ====
// Write path, status and lock control of a serial paged flash
// Assumes an array macro behind a req/ack port and an SPI master in mode 0 or 3
// Notes on behaviour
// - Write: opcode, three address bytes, data, deselect
// - Data fills buffer from low address byte
// - Write cycle starts on deselect edge
// - Write merges old bytes, erases, then programs
// - Program only clears bits, up to page
// - Busy flag high for whole internal cycle
// - Status: busy bit0, latch bit1, rest zero
// - Status flags read-only, set internally
// - Active while selected or cycle running
// - Deep sleep ignores all but wake
// - Modifying commands need clock count multiple eight
// - Modifying commands need write enable latch set
// - Latch cleared by reset and completions
// - Low top lock pin protects top sector
// - Low reset pin blocks all changes
// - One lock register per 64KB sector
// - Sectors 0, 15 add 4KB sub-locks
// - Lock registers via lock read/write commands
// - Each lock holds write-lock and lock-down
// - Write-lock set makes modifications fail
// - Write-lock clear permits, except locked top
// - Lock-down freezes register until reset
// - Lock bits cleared on any reset
`timescale 1ns/10ps
`include "flash_wp_defs.vh"

module byte_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk,
  input wire rst,
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wrPtr_reg;
  reg [AW:0] rdPtr_reg;
  wire full = (wrPtr_reg[AW] != rdPtr_reg[AW]) && (wrPtr_reg[AW-1:0] == rdPtr_reg[AW-1:0]);
  assign inReady = ~full;
  assign outValid = wrPtr_reg != rdPtr_reg;
  assign outData = mem[rdPtr_reg[AW-1:0]];
  always @(posedge clk) begin
    if (rst) begin
      wrPtr_reg <= {(AW+1){1'b0}};
      rdPtr_reg <= {(AW+1){1'b0}};
    end else begin
      if (inValid && !full) begin
        mem[wrPtr_reg[AW-1:0]] <= inData;
        wrPtr_reg <= wrPtr_reg + 1'b1;
      end
      if (outValid && outReady)
        rdPtr_reg <= rdPtr_reg + 1'b1;
    end
  end
endmodule // byte_fifo

module spi_flash_write_protect_ctrl #(
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW = 4
) (
  input wire clk,
  input wire rst,
  input wire sclk,
  input wire csN,
  input wire mosi,
  output reg miso,
  output reg misoOe,
  input wire resetN,
  input wire topBlockLockN,
  output reg arrayReq,
  output reg [2:0] arrayOp,
  output reg [19:0] arrayAddr,
  output reg [7:0] arrayWrData,
  input wire [7:0] arrayRdData,
  input wire arrayAck,
  output reg dataFifoReady,
  output reg activeMode,
  output reg deepSleep
);
  localparam S_IDLE = 5'h01;
  localparam S_DRAIN = 5'h02;
  localparam S_MERGE = 5'h04;
  localparam S_ERASE = 5'h08;
  localparam S_PROG = 5'h10;

  reg [4:0] syncA_reg;
  reg [4:0] syncB_reg;
  reg sclkPrev_reg;
  reg csPrev_reg;
  reg [7:0] shiftIn_reg;
  reg [2:0] bitCnt_reg;
  reg [2:0] byteCnt_reg;
  reg [7:0] cmd_reg;
  reg [23:0] addr_reg;
  reg [7:0] lockData_reg;
  reg [7:0] dataOff_reg;
  reg overrun_reg;
  reg [7:0] outShift_reg;
  reg [4:0] state_reg;
  reg [8:0] idx_reg;
  reg [19:0] cycAddr_reg;
  reg [7:0] kind_reg;
  reg busy_reg;
  reg wel_reg;
  reg [15:0] secWl_reg;
  reg [15:0] secLd_reg;
  reg [15:0] sub0Wl_reg;
  reg [15:0] sub0Ld_reg;
  reg [15:0] sub15Wl_reg;
  reg [15:0] sub15Ld_reg;
  reg [255:0] loaded_reg;
  reg [7:0] pageBuf [0:255];

  wire sclkS = syncB_reg[0];
  wire csS = syncB_reg[1];
  wire mosiS = syncB_reg[2];
  wire pinRstN = syncB_reg[3];
  wire tslLow = ~syncB_reg[4];
  // Pin reset acts like a full reset of state and locks
  wire hold = rst | ~pinRstN;
  wire sclkRise = sclkS & ~sclkPrev_reg & ~csS;
  wire sclkFall = ~sclkS & sclkPrev_reg & ~csS;
  wire csFall = ~csS & csPrev_reg;
  wire csRise = csS & ~csPrev_reg;
  wire [7:0] inByte = {shiftIn_reg[6:0], mosiS};
  wire byteDone = sclkRise && bitCnt_reg == 3'h7;
  wire [7:0] curCmd = (byteCnt_reg == 3'h0) ? inByte : cmd_reg;
  wire [23:0] lkAddr = (byteCnt_reg == 3'h3) ? {addr_reg[15:0], inByte} : addr_reg;
  wire wrCmd = cmd_reg == `CMD_PAGE_WRITE || cmd_reg == `CMD_PAGE_PROGRAM;
  wire dataByte = byteDone && byteCnt_reg >= `HDR_BYTES;
  wire fifoPush = dataByte && wrCmd && !busy_reg && !deepSleep;
  wire fifoInReady;
  wire fifoOutValid;
  wire [15:0] fifoOutData;
  // Drain stalls in merge, erase and program, while busy blocks every push
  wire fifoOutReady = state_reg == S_IDLE || state_reg == S_DRAIN;
  wire ok8 = bitCnt_reg == 3'h0;
  wire [3:0] sec = addr_reg[19:16];
  wire [3:0] sub = addr_reg[15:12];
  wire [7:0] statusByte = {6'h00, wel_reg, busy_reg};

  function prot;
    input [3:0] s;
    input [3:0] u;
    input [1:0] scope;
    reg topHw;
    begin
      topHw = tslLow && s == `SEC_TOP;
      if (scope == `SCOPE_CHIP)
        prot = (|secWl_reg) | (|sub0Wl_reg) | (|sub15Wl_reg) | tslLow;
      else if (scope == `SCOPE_SECTOR)
        prot = secWl_reg[s] | topHw | (s == `SEC_BOTTOM && |sub0Wl_reg) | (s == `SEC_TOP && |sub15Wl_reg);
      else
        prot = secWl_reg[s] | topHw | (s == `SEC_BOTTOM && sub0Wl_reg[u]) | (s == `SEC_TOP && sub15Wl_reg[u]);
    end
  endfunction

  // Low bits: the register a lock write with bit 7 clear reaches; bits 3:2 sector level in 0 and 15
  function [7:0] lockRead;
    input [3:0] s;
    input [3:0] u;
    begin
      if (s == `SEC_BOTTOM)
        lockRead = {4'h0, secLd_reg[s], secWl_reg[s], sub0Ld_reg[u], sub0Wl_reg[u]};
      else if (s == `SEC_TOP)
        lockRead = {4'h0, secLd_reg[s], secWl_reg[s], sub15Ld_reg[u], sub15Wl_reg[u]};
      else
        lockRead = {6'h00, secLd_reg[s], secWl_reg[s]};
    end
  endfunction

  byte_fifo #(
    .WIDTH(16),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) dataFifo (
    .clk(clk),
    .rst(hold),
    .inValid(fifoPush),
    .inReady(fifoInReady),
    .inData({dataOff_reg, inByte}),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(fifoOutData)
  );

  always @(posedge clk) begin
    if (rst) begin
      syncA_reg <= `SYNC_RESET;
      syncB_reg <= `SYNC_RESET;
    end else begin
      syncA_reg <= {topBlockLockN, resetN, mosi, csN, sclk};
      syncB_reg <= syncA_reg;
    end
  end

  // Serial front end
  always @(posedge clk) begin
    if (hold) begin
      sclkPrev_reg <= 1'b0;
      csPrev_reg <= 1'b1;
      shiftIn_reg <= 8'h00;
      bitCnt_reg <= 3'h0;
      byteCnt_reg <= 3'h0;
      cmd_reg <= 8'h00;
      addr_reg <= 24'h000000;
      lockData_reg <= 8'h00;
      dataOff_reg <= 8'h00;
      overrun_reg <= 1'b0;
      outShift_reg <= 8'h00;
      miso <= 1'b0;
      misoOe <= 1'b0;
      dataFifoReady <= 1'b0;
    end else begin
      sclkPrev_reg <= sclkS;
      csPrev_reg <= csS;
      misoOe <= ~csS;
      dataFifoReady <= fifoInReady;
      if (csFall) begin
        bitCnt_reg <= 3'h0;
        byteCnt_reg <= 3'h0;
        overrun_reg <= 1'b0;
        cmd_reg <= 8'h00;
      end
      if (sclkRise) begin
        shiftIn_reg <= inByte;
        bitCnt_reg <= bitCnt_reg + 3'h1;
      end
      if (byteDone) begin
        if (byteCnt_reg != `SAT_BYTES)
          byteCnt_reg <= byteCnt_reg + 3'h1;
        if (byteCnt_reg == 3'h0)
          cmd_reg <= inByte;
        else if (byteCnt_reg < `HDR_BYTES)
          addr_reg <= {addr_reg[15:0], inByte};
        if (byteCnt_reg == 3'h3)
          dataOff_reg <= inByte;
        if (byteCnt_reg == `HDR_BYTES)
          lockData_reg <= inByte;
        if (dataByte)
          dataOff_reg <= dataOff_reg + 8'h01;
        if (fifoPush && !fifoInReady)
          overrun_reg <= 1'b1;
        if (!deepSleep && curCmd == `CMD_STATUS_READ)
          outShift_reg <= statusByte;
        else if (!deepSleep && curCmd == `CMD_LOCK_READ && byteCnt_reg >= 3'h3)
          outShift_reg <= lockRead(lkAddr[19:16], lkAddr[15:12]);
        else
          outShift_reg <= 8'h00;
      end
      if (sclkFall) begin
        miso <= outShift_reg[7];
        outShift_reg <= {outShift_reg[6:0], 1'b0};
      end
    end
  end

  // Command decision, internal cycle and locks
  always @(posedge clk) begin
    if (hold) begin
      state_reg <= S_IDLE;
      idx_reg <= 9'h000;
      kind_reg <= 8'h00;
      cycAddr_reg <= 20'h00000;
      busy_reg <= 1'b0;
      wel_reg <= 1'b0;
      deepSleep <= 1'b0;
      activeMode <= 1'b0;
      arrayReq <= 1'b0;
      arrayOp <= `ARR_READ;
      arrayAddr <= 20'h00000;
      arrayWrData <= 8'h00;
      secWl_reg <= 16'h0000;
      secLd_reg <= 16'h0000;
      sub0Wl_reg <= 16'h0000;
      sub0Ld_reg <= 16'h0000;
      sub15Wl_reg <= 16'h0000;
      sub15Ld_reg <= 16'h0000;
      loaded_reg <= 256'h0;
    end else begin
      activeMode <= ~csS | busy_reg;
      if (fifoOutValid && fifoOutReady) begin
        pageBuf[fifoOutData[15:8]] <= fifoOutData[7:0];
        loaded_reg[fifoOutData[15:8]] <= 1'b1;
      end
      if (byteDone && byteCnt_reg == 3'h0 && !busy_reg && !deepSleep)
        if (inByte == `CMD_PAGE_WRITE || inByte == `CMD_PAGE_PROGRAM)
          loaded_reg <= 256'h0;
      if (csRise) begin
        if (deepSleep) begin
          if (cmd_reg == `CMD_WAKE && byteCnt_reg != 3'h0 && ok8)
            deepSleep <= 1'b0;
        end else if (!busy_reg && ok8) begin
          if (cmd_reg == `CMD_WRITE_ENABLE && byteCnt_reg == 3'h1)
            wel_reg <= 1'b1;
          else if (cmd_reg == `CMD_WRITE_DISABLE && byteCnt_reg == 3'h1)
            wel_reg <= 1'b0;
          else if (cmd_reg == `CMD_DEEP_SLEEP && byteCnt_reg == 3'h1)
            deepSleep <= 1'b1;
          else if (wrCmd && wel_reg && byteCnt_reg == `SAT_BYTES && !overrun_reg) begin
            if (!prot(sec, sub, `SCOPE_PAGE)) begin
              state_reg <= S_DRAIN;
              busy_reg <= 1'b1;
              kind_reg <= cmd_reg;
            end
          end else if (cmd_reg == `CMD_LOCK_WRITE && wel_reg && byteCnt_reg == `SAT_BYTES) begin
            wel_reg <= 1'b0;
            if ((sec == `SEC_BOTTOM) && !lockData_reg[`LK_SECT_SEL_BIT]) begin
              if (!sub0Ld_reg[sub]) begin
                sub0Wl_reg[sub] <= lockData_reg[`LK_WLOCK_BIT];
                sub0Ld_reg[sub] <= lockData_reg[`LK_LDOWN_BIT];
              end
            end else if ((sec == `SEC_TOP) && !lockData_reg[`LK_SECT_SEL_BIT]) begin
              if (!sub15Ld_reg[sub]) begin
                sub15Wl_reg[sub] <= lockData_reg[`LK_WLOCK_BIT];
                sub15Ld_reg[sub] <= lockData_reg[`LK_LDOWN_BIT];
              end
            end else if (!secLd_reg[sec]) begin
              secWl_reg[sec] <= lockData_reg[`LK_WLOCK_BIT];
              secLd_reg[sec] <= lockData_reg[`LK_LDOWN_BIT];
            end
          end else if (wel_reg && byteCnt_reg == `HDR_BYTES &&
                       (cmd_reg == `CMD_PAGE_CLEAR || cmd_reg == `CMD_SECTOR_CLEAR)) begin
            if (!prot(sec, sub, (cmd_reg == `CMD_PAGE_CLEAR) ? `SCOPE_PAGE : `SCOPE_SECTOR)) begin
              state_reg <= S_ERASE;
              busy_reg <= 1'b1;
              kind_reg <= cmd_reg;
            end
          end else if (cmd_reg == `CMD_CHIP_CLEAR && wel_reg && byteCnt_reg == 3'h1) begin
            if (!prot(sec, sub, `SCOPE_CHIP)) begin
              state_reg <= S_ERASE;
              busy_reg <= 1'b1;
              kind_reg <= cmd_reg;
            end
          end
        end
      end
      case (state_reg)
        S_IDLE: begin
          idx_reg <= 9'h000;
          // Status polls keep shifting the address; freeze it for the cycle
          cycAddr_reg <= addr_reg[19:0];
        end
        S_DRAIN: begin
          // Buffer must hold every byte before the merge looks at it
          if (!fifoOutValid)
            state_reg <= (kind_reg == `CMD_PAGE_WRITE) ? S_MERGE : S_PROG;
        end
        S_MERGE: begin
          if (idx_reg == `PAGE_BYTES) begin
            state_reg <= S_ERASE;
            idx_reg <= 9'h000;
          end else if (loaded_reg[idx_reg[7:0]]) begin
            idx_reg <= idx_reg + 9'h001;
          end else if (!arrayReq) begin
            arrayReq <= 1'b1;
            arrayOp <= `ARR_READ;
            arrayAddr <= {cycAddr_reg[19:8], idx_reg[7:0]};
          end else if (arrayAck) begin
            arrayReq <= 1'b0;
            pageBuf[idx_reg[7:0]] <= arrayRdData;
            idx_reg <= idx_reg + 9'h001;
          end
        end
        S_ERASE: begin
          if (!arrayReq) begin
            arrayReq <= 1'b1;
            arrayAddr <= cycAddr_reg;
            if (kind_reg == `CMD_SECTOR_CLEAR)
              arrayOp <= `ARR_ERASE_SECTOR;
            else if (kind_reg == `CMD_CHIP_CLEAR)
              arrayOp <= `ARR_ERASE_CHIP;
            else
              arrayOp <= `ARR_ERASE_PAGE;
          end else if (arrayAck) begin
            arrayReq <= 1'b0;
            if (kind_reg == `CMD_PAGE_WRITE) begin
              state_reg <= S_PROG;
            end else begin
              state_reg <= S_IDLE;
              busy_reg <= 1'b0;
              wel_reg <= 1'b0;
            end
          end
        end
        S_PROG: begin
          if (idx_reg == `PAGE_BYTES) begin
            state_reg <= S_IDLE;
            busy_reg <= 1'b0;
            wel_reg <= 1'b0;
          end else if (kind_reg == `CMD_PAGE_PROGRAM && !loaded_reg[idx_reg[7:0]]) begin
            idx_reg <= idx_reg + 9'h001;
          end else if (!arrayReq) begin
            arrayReq <= 1'b1;
            arrayOp <= `ARR_PROG;
            arrayAddr <= {cycAddr_reg[19:8], idx_reg[7:0]};
            arrayWrData <= pageBuf[idx_reg[7:0]];
          end else if (arrayAck) begin
            arrayReq <= 1'b0;
            idx_reg <= idx_reg + 9'h001;
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end
endmodule // spi_flash_write_protect_ctrl

// ==== verilog/flash_wp_defs.vh ====
// Constants of the serial flash write and protection controller
// Assumes inclusion by bare name from the controller source
`ifndef FLASH_WP_DEFS_VH
`define FLASH_WP_DEFS_VH
`define CMD_WRITE_ENABLE 8'h06
`define CMD_WRITE_DISABLE 8'h04
`define CMD_STATUS_READ 8'h05
`define CMD_PAGE_WRITE 8'h0A
`define CMD_PAGE_PROGRAM 8'h02
`define CMD_PAGE_CLEAR 8'hDB
`define CMD_SECTOR_CLEAR 8'hD8
`define CMD_CHIP_CLEAR 8'hC7
`define CMD_DEEP_SLEEP 8'hB9
`define CMD_WAKE 8'hAB
`define CMD_LOCK_WRITE 8'hE5
`define CMD_LOCK_READ 8'hE8
`define ARR_READ 3'h0
`define ARR_PROG 3'h1
`define ARR_ERASE_PAGE 3'h2
`define ARR_ERASE_SECTOR 3'h3
`define ARR_ERASE_CHIP 3'h4
`define ST_BUSY_BIT 0
`define ST_WEL_BIT 1
`define LK_WLOCK_BIT 0
`define LK_LDOWN_BIT 1
`define LK_SECT_SEL_BIT 7
`define SEC_BOTTOM 4'h0
`define SEC_TOP 4'hF
`define HDR_BYTES 3'h4
`define SAT_BYTES 3'h5
`define PAGE_BYTES 9'h100
`define SCOPE_PAGE 2'h0
`define SCOPE_SECTOR 2'h1
`define SCOPE_CHIP 2'h2
`define SYNC_RESET 5'h1A
`endif

// ==== tb/flash_wp_properties.sv ====
// Port timing relations of the flash write and protection controller
// Assumes binding onto the controller top, clk domain, rst sync high
`timescale 1ns/10ps
module flash_wp_properties (
  input wire clk,
  input wire rst,
  input wire csN,
  input wire resetN,
  input wire misoOe,
  input wire arrayReq,
  input wire [2:0] arrayOp,
  input wire [19:0] arrayAddr,
  input wire [7:0] arrayWrData,
  input wire arrayAck,
  input wire activeMode,
  input wire deepSleep
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_req_hold: assert property (arrayReq && !arrayAck && resetN |=> arrayReq && $stable({arrayOp, arrayAddr, arrayWrData}))
    else $error("array request changed before ack");
  a_req_drop: assert property (arrayAck |=> !arrayReq)
    else $error("array request held after ack");
  a_oe_on: assert property ($fell(csN) && resetN |-> ##[2:5] misoOe)
    else $error("output enable late after select");
  a_oe_off: assert property ($rose(csN) |-> ##[2:5] !misoOe)
    else $error("output enable stuck after deselect");
  a_active_sel: assert property ($fell(csN) && resetN |-> ##[2:5] activeMode)
    else $error("not active while selected");
  a_active_busy: assert property (arrayReq |-> activeMode)
    else $error("standby during internal cycle");
  a_sleep_idle: assert property (deepSleep |-> !arrayReq)
    else $error("array cycle in deep sleep");
  a_pin_block: assert property ((!resetN)[*5] |-> !arrayReq && !deepSleep)
    else $error("array cycle while reset pin low");
endmodule // flash_wp_properties

// ==== tb/spi_master_model.sv ====
// SPI bus master in mode 0 driving the controller pins
// Assumes the bench clock; pins change 1 ns after clk rises
`timescale 1ns/10ps
module spi_master_model (
  input wire clk,
  output reg sclk,
  output reg csN,
  output reg mosi,
  input wire miso
);
  int half = 4;
  initial begin
    sclk = 1'b0;
    csN = 1'b1;
    mosi = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic bitx(input logic d, output logic q);
    mosi = d;
    tick(half);
    sclk = 1'b1;
    q = miso;
    tick(half);
    sclk = 1'b0;
  endtask
  // One instruction per select; extra bits leave the bit count off a multiple of eight
  task automatic xfer(input logic [7:0] tx[$], input int nrx, input int extra, output logic [7:0] rx[$]);
    logic [7:0] b;
    int i;
    int k;
    rx = {};
    tick(1);
    csN = 1'b0;
    for (i = 0; i < tx.size() + nrx; i++) begin
      for (k = 7; k >= 0; k--) begin
        bitx((i < tx.size()) ? tx[i][k] : 1'b0, b[k]);
      end
      if (i >= tx.size()) rx.push_back(b);
    end
    for (i = 0; i < extra; i++) bitx(1'b1, b[0]);
    tick(half);
    csN = 1'b1;
    mosi = ~mosi;
    tick(half);
  endtask
endmodule // spi_master_model

// ==== tb/spi_flash_write_protect_ctrl_test.sv ====
// Self-checking bench of the flash write and protection controller
// Assumes the SPI master model and a behavioural array macro kept here
`timescale 1ns/10ps
module spi_flash_write_protect_ctrl_test;
  logic clk, rst, resetN, topBlockLockN, arrayAck, arrayReq, miso, misoOe, sclk, csN, mosi;
  logic dataFifoReady, activeMode, deepSleep;
  logic [2:0] arrayOp;
  logic [19:0] arrayAddr;
  logic [7:0] arrayWrData, arrayRdData;
  logic [7:0] mem[int];
  logic [7:0] want[int];
  logic [7:0] rx[$];
  int err_total = 0;
  int compares = 0;
  int lat = 0;
  logic sawBusy;
  // Undriven output shows its inverse, so a late enable breaks the read
  spi_master_model mst (.clk(clk), .sclk(sclk), .csN(csN), .mosi(mosi), .miso(misoOe ? miso : ~miso));
  spi_flash_write_protect_ctrl dut (.clk(clk), .rst(rst), .sclk(sclk), .csN(csN), .mosi(mosi), .miso(miso),
    .misoOe(misoOe), .resetN(resetN), .topBlockLockN(topBlockLockN), .arrayReq(arrayReq), .arrayOp(arrayOp),
    .arrayAddr(arrayAddr), .arrayWrData(arrayWrData), .arrayRdData(arrayRdData), .arrayAck(arrayAck),
    .dataFifoReady(dataFifoReady), .activeMode(activeMode), .deepSleep(deepSleep));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  function automatic logic [7:0] rdm(input logic [19:0] a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction
  function automatic logic [7:0] rdw(input logic [19:0] a);
    return want.exists(a) ? want[a] : 8'hFF;
  endfunction
  // Array macro with random latency, so slow and prompt acks both occur
  always @(posedge clk) begin
    #1;
    arrayAck = 1'b0;
    if (arrayReq && lat > 0) lat--;
    else if (arrayReq) begin
      arrayAck = 1'b1;
      lat = $urandom_range(3);
      case (arrayOp)
        3'h0: arrayRdData = rdm(arrayAddr);
        3'h1: mem[arrayAddr] = rdm(arrayAddr) & arrayWrData;
        3'h2: for (int i = 0; i < 256; i++) mem.delete({arrayAddr[19:8], 8'(i)});
        3'h3: for (int i = 0; i < 65536; i++) mem.delete({arrayAddr[19:16], 16'(i)});
        default: mem.delete();
      endcase
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    if (err_total == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cmd(input logic [7:0] op);
    mst.xfer({op}, 0, 0, rx);
  endtask
  task automatic stat(input logic [7:0] exp);
    mst.xfer({8'h05}, 1, 0, rx);
    chk(rx[0], exp);
  endtask
  task automatic waitIdle;
    int n;
    sawBusy = 1'b0;
    for (n = 0; n < 300; n++) begin
      mst.xfer({8'h05}, 1, 0, rx);
      if (rx[0][0] !== 1'b1) break;
      sawBusy = 1'b1;
    end
    if (n == 300) begin
      err_total++;
      final_report();
    end
  endtask
  // Sends a write or program, updates the reference page, compares it
  task automatic pgw(input logic [7:0] op, input logic [19:0] a, input int n, input int ok, input int ext);
    logic [7:0] tx[$];
    logic [7:0] d;
    logic [19:0] p;
    int k;
    tx = {op, 8'(a[19:16]), a[15:8], a[7:0]};
    for (k = 0; k < n; k++) begin
      d = 8'($urandom);
      tx.push_back(d);
      p = {a[19:8], a[7:0] + 8'(k)};
      if (ok) want[p] = (op == 8'h02) ? (rdw(p) & d) : d;
    end
    mst.xfer(tx, 0, ext, rx);
    waitIdle();
    for (k = 0; k < 256; k++) chk(rdm({a[19:8], 8'(k)}), rdw({a[19:8], 8'(k)}));
  endtask
  // Page, sector or chip erase; the reference forgets what it covered
  task automatic ers(input logic [7:0] op, input logic [19:0] a, input int ok);
    int q[$];
    int k;
    cmd(8'h06);
    if (op == 8'hC7) mst.xfer({op}, 0, 0, rx);
    else mst.xfer({op, 8'(a[19:16]), a[15:8], a[7:0]}, 0, 0, rx);
    waitIdle();
    foreach (want[x]) begin
      if (ok && (op == 8'hC7 || x[19:8] == a[19:8] || (op == 8'hD8 && x[19:16] == a[19:16]))) q.push_back(x);
    end
    foreach (q[j]) want.delete(q[j]);
    for (k = 0; k < 256; k++) chk(rdm({a[19:8], 8'(k)}), rdw({a[19:8], 8'(k)}));
  endtask
  task automatic lk(input logic [19:0] a, input logic [7:0] d);
    cmd(8'h06);
    mst.xfer({8'hE5, 8'(a[19:16]), a[15:8], a[7:0], d}, 0, 0, rx);
    waitIdle();
  endtask
  task automatic lr(input logic [19:0] a, input logic [7:0] exp);
    mst.xfer({8'hE8, 8'(a[19:16]), a[15:8], a[7:0]}, 1, 0, rx);
    chk(rx[0] & 8'h03, exp);
  endtask
  initial begin
    rst = 1'b1;
    resetN = 1'b1;
    topBlockLockN = 1'b1;
    arrayAck = 1'b0;
    arrayRdData = 8'h00;
    void'($urandom(32'hCADAAE31));
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    mst.tick(6);
    chk(dataFifoReady, 1'b1);
    stat(8'h00);
    pgw(8'h0A, 20'h312FE, 3, 0, 0);
    cmd(8'h06);
    stat(8'h02);
    pgw(8'h0A, 20'h312FE, 3, 1, 0);
    chk(sawBusy, 1'b1);
    stat(8'h00);
    cmd(8'h06);
    mst.half = 6;
    pgw(8'h02, 20'h312FF, 4, 1, 0);
    mst.half = 4;
    cmd(8'h06);
    pgw(8'h0A, 20'h31200, 2, 0, 3);
    stat(8'h02);
    cmd(8'h04);
    stat(8'h00);
    lk(20'h30000, 8'h01);
    stat(8'h00);
    lr(20'h30000, 8'h01);
    cmd(8'h06);
    pgw(8'h0A, 20'h30010, 2, 0, 0);
    lk(20'h30000, 8'h03);
    lk(20'h30000, 8'h00);
    lr(20'h30000, 8'h03);
    ers(8'hDB, 20'h31200, 0);
    lk(20'h01000, 8'h01);
    cmd(8'h06);
    pgw(8'h0A, 20'h01000, 1, 0, 0);
    pgw(8'h0A, 20'h02000, 1, 1, 0);
    ers(8'hD8, 20'h02000, 0);
    ers(8'hDB, 20'h02000, 1);
    topBlockLockN = 1'b0;
    cmd(8'h06);
    pgw(8'h0A, 20'hF0000, 1, 0, 0);
    topBlockLockN = 1'b1;
    pgw(8'h0A, 20'hF0000, 1, 1, 0);
    cmd(8'hB9);
    mst.tick(8);
    chk(deepSleep, 1'b1);
    cmd(8'h06);
    cmd(8'hAB);
    mst.tick(8);
    chk(deepSleep, 1'b0);
    stat(8'h00);
    cmd(8'h06);
    resetN = 1'b0;
    mst.tick(8);
    mst.xfer({8'h0A, 8'h03, 8'h00, 8'h20, 8'h5A}, 0, 0, rx);
    resetN = 1'b1;
    mst.tick(6);
    stat(8'h00);
    lr(20'h30000, 8'h00);
    pgw(8'h0A, 20'h30020, 0, 0, 0);
    ers(8'hC7, 20'h31200, 1);
    final_report();
  end
endmodule // spi_flash_write_protect_ctrl_test
bind spi_flash_write_protect_ctrl flash_wp_properties props (.clk(clk), .rst(rst), .csN(csN), .resetN(resetN),
  .misoOe(misoOe), .arrayReq(arrayReq), .arrayOp(arrayOp), .arrayAddr(arrayAddr), .arrayWrData(arrayWrData),
  .arrayAck(arrayAck), .activeMode(activeMode), .deepSleep(deepSleep));
